// File: hdl/rth_top.sv
`timescale 1ns/10ps
`include "rth_regs.svh"
module rth_top #(
    parameter int TIMER_CYC = `RTH_TIMER_CYC
) (
    // clock, reset, enable
    input  wire logic              CLOCK,
    input  wire logic              RESETN,
    input  wire logic              CE,
    // user side, same clock
    input  wire logic              XFER_START,
    input  wire rth_pkg::rth_xfer_s XFER_IN,
    output logic                   XFER_BUSY,
    output logic                   XFER_DONE,
    output logic [15:0]            XFER_RDATA,
    input  wire logic              PARITY_DONE,
    input  wire rth_pkg::rth_cmd_s CMD_IN,
    input  wire logic              MSG_ERR_SET,
    input  wire logic              STATUS_TX,
    input  wire logic [15:0]       SYSTEM_REG,
    output logic                   TX_PERMIT,
    // memory side pins
    output logic                   XFER_REQUEST,
    input  wire logic              MEM_STROBE,
    input  wire logic              MEM_CHIP_SEL_N,
    input  wire logic              HOST_READ_WRITE,
    output logic                   MEM_READ_WRITE,
    input  wire logic              ADDR_OUT_ENABLE_N,
    output logic [10:0]            ADDR_OUT,
    output logic                   ADDR_OUT_OE,
    // register read pins and data bus
    input  wire logic              READ_CTRL_N,
    input  wire logic              ADDR_IN0,
    input  wire logic [15:0]       DATA_IN,
    output logic [15:0]            DATA_OUT,
    output logic                   DATA_OE,
    // command status pins
    output logic                   COMMAND_STROBE,
    output logic                   RECEIVE_IND,
    output logic                   TRANSMIT_IND,
    output logic                   CHANNEL_IND,
    output logic [15:0]            CMD_STATUS,
    output logic                   MESSAGE_ERROR,
    output logic                   FAILSAFE_TIMER_OUT_N
);
    localparam int STRB_CYC = `RTH_STRB_CYC;
    localparam int END_CYC  = `RTH_STRB_CYC + `RTH_ERRCLR_CYC;
    // counters are 16 and 6 bits; status must lead the strobe
    if (TIMER_CYC < 1 || TIMER_CYC > 65535 || END_CYC > 63 ||
        `RTH_CHAN_CYC > STRB_CYC - `RTH_STAT_LEAD_CYC) begin
        $error("timer or command sequence counts out of range");
    end
    // ==========================================================
    // pin synchronisers, reset to idle levels (selects negated)
    localparam int NS = 22;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            sync1 <= 22'h00003E;
            sync2 <= 22'h00003E;
        end else if (CE) begin
            sync1 <= {DATA_IN, READ_CTRL_N, ADDR_OUT_ENABLE_N, MEM_CHIP_SEL_N,
                      HOST_READ_WRITE, ADDR_IN0, MEM_STROBE};
            sync2 <= sync1;
        end
    end
    logic        s_strobe, s_a0, s_rw, s_cs_n, s_aoe_n, s_rd_n;
    logic [15:0] s_data;
    assign {s_data, s_rd_n, s_aoe_n, s_cs_n, s_rw, s_a0, s_strobe} = sync2;
    // ==========================================================
    // host strobe qualification
    logic strobe_d;
    logic cs_free;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            strobe_d <= 1'b0;
            cs_free  <= 1'b1;
        end else if (CE) begin
            strobe_d <= s_strobe;
            cs_free  <= s_cs_n;
        end
    end
    // chip select must have been negated for a whole sample already
    wire strobe_rise = s_strobe && !strobe_d && s_cs_n && cs_free;
    wire strobe_fall = !s_strobe && strobe_d;
    // ==========================================================
    // transfer sequencer
    rth_pkg::rth_xfer_e state;
    rth_pkg::rth_xfer_s cur;
    logic [3:0]         setup_cnt;
    logic               accepted;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state        <= rth_pkg::X_IDLE;
            cur          <= '0;
            setup_cnt    <= 4'h0;
            accepted     <= 1'b0;
            XFER_REQUEST <= 1'b0;
            XFER_BUSY    <= 1'b0;
            XFER_DONE    <= 1'b0;
            XFER_RDATA   <= 16'h0000;
        end else if (CE) begin
            XFER_DONE <= 1'b0;
            case (state)
                rth_pkg::X_IDLE: begin
                    if (XFER_START) begin
                        cur       <= XFER_IN;
                        setup_cnt <= 4'h0;
                        accepted  <= 1'b0;
                        XFER_BUSY <= 1'b1;
                        state     <= rth_pkg::X_SETUP;
                    end
                end
                rth_pkg::X_SETUP: begin
                    setup_cnt <= setup_cnt + 4'h1;
                    if (setup_cnt == 4'(`RTH_ADDR_CYC)) begin
                        XFER_REQUEST <= 1'b1;
                        state        <= rth_pkg::X_REQ;
                    end
                end
                rth_pkg::X_REQ: begin
                    if (strobe_rise)
                        accepted <= 1'b1;
                    if (accepted && strobe_fall) begin
                        if (!cur.to_mem)
                            XFER_RDATA <= s_data;
                        XFER_REQUEST <= 1'b0;
                        state        <= rth_pkg::X_DONE;
                    end
                end
                rth_pkg::X_DONE: begin
                    XFER_BUSY <= 1'b0;
                    XFER_DONE <= 1'b1;
                    state     <= rth_pkg::X_IDLE;
                end
                default: state <= rth_pkg::X_IDLE;
            endcase
        end
    end
    wire in_xfer = (state != rth_pkg::X_IDLE);
    wire wr_drive = (state == rth_pkg::X_REQ) && accepted && cur.to_mem && s_strobe;
    // ==========================================================
    // address and read/write pins
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ADDR_OUT       <= 11'h000;
            ADDR_OUT_OE    <= 1'b0;
            MEM_READ_WRITE <= 1'b1;
        end else if (CE) begin
            ADDR_OUT    <= cur.addr;
            ADDR_OUT_OE <= !s_aoe_n;
            if (in_xfer)
                MEM_READ_WRITE <= !cur.to_mem;
            else
                MEM_READ_WRITE <= s_rw;
        end
    end

    // ==========================================================
    // data bus: memory write data wins over a register read
    logic [15:0] last_cmd;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            DATA_OUT <= 16'h0000;
            DATA_OE  <= 1'b0;
        end else if (CE) begin
            if (wr_drive) begin
                DATA_OUT <= cur.data;
                DATA_OE  <= 1'b1;
            end else if (!s_rd_n) begin
                DATA_OUT <= (s_a0 == `RTH_SEL_LASTCMD) ? last_cmd : SYSTEM_REG;
                DATA_OE  <= 1'b1;
            end else begin
                DATA_OE  <= 1'b0;
            end
        end
    end

    // ==========================================================
    // command sequence, one counter from parity to error clear
    rth_pkg::rth_cmd_s cmd;
    logic [5:0]        cmd_cnt;
    logic              cmd_run;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            cmd      <= '0;
            last_cmd <= 16'h0000;
            cmd_cnt  <= 6'h00;
            cmd_run  <= 1'b0;
        end else if (CE) begin
            if (PARITY_DONE) begin
                cmd      <= CMD_IN;
                last_cmd <= CMD_IN.word;
                cmd_cnt  <= 6'h01;
                cmd_run  <= 1'b1;
            end else if (cmd_run) begin
                cmd_cnt <= cmd_cnt + 6'h01;
                if (cmd_cnt == 6'(END_CYC))
                    cmd_run <= 1'b0;
            end
        end
    end
    wire at_chan   = cmd_run && cmd_cnt == 6'(`RTH_CHAN_CYC);
    wire at_strobe = cmd_run && cmd_cnt == 6'(STRB_CYC);
    wire at_sdrop  = cmd_run && cmd_cnt == 6'(STRB_CYC + `RTH_PULSE_CYC);
    wire at_errclr = cmd_run && cmd_cnt == 6'(END_CYC);

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            COMMAND_STROBE <= 1'b0;
            RECEIVE_IND    <= 1'b0;
            TRANSMIT_IND   <= 1'b0;
            CHANNEL_IND    <= 1'b0;
            CMD_STATUS     <= 16'h0000;
        end else if (CE) begin
            if (PARITY_DONE) begin
                RECEIVE_IND  <= 1'b0;
                TRANSMIT_IND <= 1'b0;
            end
            if (at_chan) begin
                CHANNEL_IND <= cmd.chan_a;
                CMD_STATUS  <= cmd.word;
            end
            if (at_strobe) begin
                COMMAND_STROBE <= 1'b1;
                RECEIVE_IND    <= !cmd.is_tx;
                TRANSMIT_IND   <= cmd.is_tx;
            end
            if (at_sdrop)
                COMMAND_STROBE <= 1'b0;
        end
    end

    // a new error arriving in the clear cycle survives
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN)
            MESSAGE_ERROR <= 1'b0;
        else if (CE) begin
            if (MSG_ERR_SET)
                MESSAGE_ERROR <= 1'b1;
            else if (at_errclr)
                MESSAGE_ERROR <= 1'b0;
        end
    end

    // ==========================================================
    // fail-safe transmitter timer, active low
    logic [15:0] tmr_cnt;
    logic [3:0]  lead_cnt;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            FAILSAFE_TIMER_OUT_N <= 1'b1;
            TX_PERMIT            <= 1'b0;
            tmr_cnt              <= 16'h0000;
            lead_cnt             <= 4'h0;
        end else if (CE) begin
            if (at_strobe) begin
                FAILSAFE_TIMER_OUT_N <= 1'b1;
                TX_PERMIT            <= 1'b0;
            end else if (STATUS_TX && FAILSAFE_TIMER_OUT_N) begin
                FAILSAFE_TIMER_OUT_N <= 1'b0;
                tmr_cnt              <= 16'(TIMER_CYC - 1);
                lead_cnt             <= 4'h1;
            end else if (!FAILSAFE_TIMER_OUT_N) begin
                if (tmr_cnt == 16'h0000) begin
                    FAILSAFE_TIMER_OUT_N <= 1'b1;
                    TX_PERMIT            <= 1'b0;
                end else begin
                    tmr_cnt <= tmr_cnt - 16'h0001;
                end
                if (lead_cnt != 4'(`RTH_TX_LEAD_CYC))
                    lead_cnt <= lead_cnt + 4'h1;
                else
                    TX_PERMIT <= 1'b1;
            end
        end
    end

endmodule

// File: inc/rth_regs.svh
`ifndef RTH_REGS_SVH
`define RTH_REGS_SVH

// ==========================================================
// clock
`define RTH_CLK_NS          100

// ==========================================================
// transfer sequencing
`define RTH_ADDR_MIN_NS     883
`define RTH_ADDR_MAX_NS     992
`define RTH_ADDR_CYC        ((`RTH_ADDR_MIN_NS + `RTH_CLK_NS - 1) / `RTH_CLK_NS)

// ==========================================================
// command sequencing, counted from the parity pulse
`define RTH_CHAN_MIN_NS     2580
`define RTH_CHAN_CYC        ((`RTH_CHAN_MIN_NS + `RTH_CLK_NS - 1) / `RTH_CLK_NS)
`define RTH_STRB_MIN_NS     3580
`define RTH_STRB_CYC        ((`RTH_STRB_MIN_NS + `RTH_CLK_NS - 1) / `RTH_CLK_NS)
`define RTH_STAT_LEAD_NS    430
`define RTH_STAT_LEAD_CYC   ((`RTH_STAT_LEAD_NS + `RTH_CLK_NS - 1) / `RTH_CLK_NS)
`define RTH_PULSE_MIN_NS    499
`define RTH_PULSE_CYC       ((`RTH_PULSE_MIN_NS + `RTH_CLK_NS - 1) / `RTH_CLK_NS)
`define RTH_ERRCLR_MIN_NS   745
`define RTH_ERRCLR_CYC      ((`RTH_ERRCLR_MIN_NS + `RTH_CLK_NS - 1) / `RTH_CLK_NS)

// ==========================================================
// fail-safe timer
`define RTH_TX_LEAD_NS      1200
`define RTH_TX_LEAD_CYC     ((`RTH_TX_LEAD_NS + `RTH_CLK_NS - 1) / `RTH_CLK_NS)
`define RTH_TIMER_MAX_US    732
`define RTH_TIMER_CYC       ((`RTH_TIMER_MAX_US * 1000) / `RTH_CLK_NS)

// ==========================================================
// register read select on address bit 0
`define RTH_SEL_SYSTEM      1'h0
`define RTH_SEL_LASTCMD     1'h1

`endif

// File: inc/rth_pkg.sv
package rth_pkg;

    typedef enum logic [1:0] {
        X_IDLE  = 2'b00,
        X_SETUP = 2'b01,
        X_REQ   = 2'b10,
        X_DONE  = 2'b11
    } rth_xfer_e;

    // one word to move between the device and shared memory
    typedef struct packed {
        logic        to_mem;
        logic [10:0] addr;
        logic [15:0] data;
    } rth_xfer_s;

    // a decoded command word at its parity bit
    typedef struct packed {
        logic [15:0] word;
        logic        is_tx;
        logic        chan_a;
    } rth_cmd_s;

endpackage

// File: verif/rth_top_sva.sv
`timescale 1ns/10ps
module rth_top_sva #(
    parameter int TIMER_CYC = 50
) (
    // clock and reset
    input wire logic              CLOCK,
    input wire logic              RESETN,
    // transfer and command pins
    input wire logic              XFER_START,
    input wire logic              XFER_REQUEST,
    input wire logic [10:0]       ADDR_OUT,
    input wire logic              PARITY_DONE,
    input wire rth_pkg::rth_cmd_s CMD_IN,
    input wire logic              MSG_ERR_SET,
    input wire logic              STATUS_TX,
    input wire logic              COMMAND_STROBE,
    input wire logic              CHANNEL_IND,
    input wire logic              MESSAGE_ERROR,
    input wire logic              FAILSAFE_TIMER_OUT_N
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // ==========================================
    // timer low time, counted so no long repetition is unrolled
    int unsigned low_cyc;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN)
            low_cyc <= '0;
        else if (FAILSAFE_TIMER_OUT_N)
            low_cyc <= '0;
        else
            low_cyc <= low_cyc + 1;
    end
    // ==========================================
    // checks
    a_addr_before_req: assert property ($rose(XFER_REQUEST) |->
        $past(XFER_START, 11) && $past(ADDR_OUT, 9) == ADDR_OUT) else $error("address early");
    a_strobe_delay: assert property ($rose(COMMAND_STROBE) |->
        $past(PARITY_DONE, 37)) else $error("command strobe delay wrong");
    a_strobe_width: assert property ($rose(COMMAND_STROBE) |->
        COMMAND_STROBE [*5] ##1 !COMMAND_STROBE) else $error("command strobe width wrong");
    a_chan_delay: assert property (PARITY_DONE |->
        ##27 CHANNEL_IND == $past(CMD_IN.chan_a, 27)) else $error("channel late");
    a_err_clear: assert property ($rose(COMMAND_STROBE) |->
        ##8 (!MESSAGE_ERROR || $past(MSG_ERR_SET))) else $error("error not cleared");
    a_timer_start: assert property (STATUS_TX && FAILSAFE_TIMER_OUT_N |=>
        !FAILSAFE_TIMER_OUT_N) else $error("timer not started");
    a_timer_limit: assert property (!FAILSAFE_TIMER_OUT_N |->
        low_cyc < TIMER_CYC) else $error("timer too long");
    a_timer_reset: assert property ($rose(COMMAND_STROBE) |->
        FAILSAFE_TIMER_OUT_N) else $error("timer not reset");
    c_xfer: cover property ($fell(XFER_REQUEST));
    c_cmd: cover property ($rose(COMMAND_STROBE));
    c_timer: cover property ($fell(FAILSAFE_TIMER_OUT_N));
endmodule

bind rth_top rth_top_sva #(.TIMER_CYC(TIMER_CYC)) sva_u (
    .CLOCK(CLOCK), .RESETN(RESETN), .XFER_START(XFER_START),
    .XFER_REQUEST(XFER_REQUEST), .ADDR_OUT(ADDR_OUT), .PARITY_DONE(PARITY_DONE),
    .CMD_IN(CMD_IN), .MSG_ERR_SET(MSG_ERR_SET), .STATUS_TX(STATUS_TX),
    .COMMAND_STROBE(COMMAND_STROBE), .CHANNEL_IND(CHANNEL_IND),
    .MESSAGE_ERROR(MESSAGE_ERROR), .FAILSAFE_TIMER_OUT_N(FAILSAFE_TIMER_OUT_N)
);

// File: verif/rth_host_mdl.sv
`timescale 1ns/10ps
module rth_host_mdl (
    // bench control
    input  wire logic        clk,
    input  wire logic [7:0]  dly,
    input  wire logic        bad,
    input  wire logic [15:0] rd_word,
    output logic [15:0]      wr_word,
    output logic             ign_ok,
    // device pins
    input  wire logic        req,
    input  wire logic        rw,
    input  wire logic [15:0] dout,
    input  wire logic        doe,
    output logic             strobe,
    output logic             cs_n,
    output logic [15:0]      din
);
    logic is_rd;
    // ==========================================
    // shared memory side
    initial begin
        strobe = 1'h0;
        cs_n = 1'h1;
        din = 16'h0;
        wr_word = 16'h0;
        ign_ok = 1'h0;
    end
    always begin
        @(negedge clk);
        if (req === 1'h1) begin
            is_rd = rw;
            // waits stay far below the 14.9/18.3/18.8 us ceilings
            repeat (dly) @(negedge clk);
            if (bad) begin
                cs_n = 1'h0;
                strobe = 1'h1;
                repeat (3) @(negedge clk);
                strobe = 1'h0;
                cs_n = 1'h1;
                repeat (4) @(negedge clk);
                ign_ok = req;
            end
            if (is_rd)
                din = rd_word;
            strobe = 1'h1;
            repeat (4) @(negedge clk);
            if (!is_rd)
                wr_word = doe ? dout : 16'h0;
            strobe = 1'h0;
            repeat (3) @(negedge clk);
            // released bus must not keep the old word
            din = ~din;
            while (req === 1'h1) @(negedge clk);
        end
    end
endmodule

// File: verif/rt_subsystem_handshake_timing_tb_top.sv
`timescale 1ns/10ps
module rt_subsystem_handshake_timing_tb_top;
    localparam int TCYC = 50;
    logic clk = 1'h0;
    logic rst_n, xs, done, pd, mes, stx, permit, req, stb, cs_n, hrw, mrw, busy;
    logic aoe_n, aoe, rd_n, a0, doe, cstb, receive_ind, xmt, chan, merr, tmr_n, bad, ign_ok;
    logic [15:0] rdata, sysr, din, dout, wr_word, md, cstat;
    logic [10:0] aout;
    logic [7:0] dly;
    rth_pkg::rth_xfer_s xin;
    rth_pkg::rth_cmd_s cin;
    int err_total, checked, cyc;
    rth_top #(.TIMER_CYC(TCYC)) dut_u (
        .CLOCK(clk), .RESETN(rst_n), .CE(1'h1), .XFER_START(xs), .XFER_IN(xin),
        .XFER_BUSY(busy), .XFER_DONE(done), .XFER_RDATA(rdata), .PARITY_DONE(pd),
        .CMD_IN(cin), .MSG_ERR_SET(mes), .STATUS_TX(stx), .SYSTEM_REG(sysr),
        .TX_PERMIT(permit), .XFER_REQUEST(req), .MEM_STROBE(stb), .MEM_CHIP_SEL_N(cs_n),
        .HOST_READ_WRITE(hrw), .MEM_READ_WRITE(mrw), .ADDR_OUT_ENABLE_N(aoe_n),
        .ADDR_OUT(aout), .ADDR_OUT_OE(aoe), .READ_CTRL_N(rd_n), .ADDR_IN0(a0),
        .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .COMMAND_STROBE(cstb),
        .RECEIVE_IND(receive_ind), .TRANSMIT_IND(xmt), .CHANNEL_IND(chan), .CMD_STATUS(cstat),
        .MESSAGE_ERROR(merr), .FAILSAFE_TIMER_OUT_N(tmr_n)
    );
    rth_host_mdl mdl_u (
        .clk(clk), .dly(dly), .bad(bad), .rd_word(md), .wr_word(wr_word), .ign_ok(ign_ok),
        .req(req), .rw(mrw), .dout(dout), .doe(doe), .strobe(stb), .cs_n(cs_n), .din(din)
    );
    // ==========================================
    // clock, hang guard, helpers
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic xfer(input logic tm, input logic [10:0] ad, input logic [15:0] dt,
                        input logic [7:0] d, input logic b);
        int w;
        dly = d;
        bad = b;
        md = dt;
        xin = '{to_mem: tm, addr: ad, data: dt};
        xs = 1'h1;
        tick(1);
        xs = 1'h0;
        w = 0;
        while (req !== 1'h1 && w < 20) begin
            tick(1);
            w++;
        end
        chk("addr_out", 16'(aout), 16'(ad));
        chk("busy", 16'(busy), 16'h1);
        w = 0;
        while (done !== 1'h1 && w < 400) begin
            tick(1);
            w++;
        end
        chk("done", 16'(done), 16'h1);
        chk("busy_end", 16'(busy), 16'h0);
        chk("word", tm ? wr_word : rdata, dt);
        if (b)
            chk("ignored", 16'(ign_ok), 16'h1);
        tick(1);
    endtask
    // ==========================================
    // sequence
    initial begin
        {rst_n, xs, pd, mes, stx, bad, aoe_n, a0} = 8'h0;
        {hrw, rd_n} = 2'h3;
        sysr = 16'h5A3C;
        cin = '0;
        xin = '0;
        dly = 8'h3;
        md = 16'h0;
        tick(1);
        chk("rw_reset", 16'(mrw), 16'h1);
        chk("timer_reset", 16'(tmr_n), 16'h1);
        tick(1);
        rst_n = 1'h1;
        xfer(1'h1, 11'h2A5, 16'hC3A5, 8'h03, 1'h0);
        xfer(1'h0, 11'h15A, 16'h3CA5, 8'h64, 1'h0);
        xfer(1'h1, 11'h7FF, 16'h9669, 8'h02, 1'h1);
        for (int i = 0; i < 2; i++) begin
            hrw = i[0];
            aoe_n = i[0];
            tick(4);
            chk("mem_rw", 16'(mrw), 16'(i[0]));
            chk("addr_oe", 16'(aoe), 16'(!i[0]));
        end
        // both command directions, timer running into each strobe
        for (int k = 0; k < 2; k++) begin
            mes = 1'h1;
            tick(1);
            mes = 1'h0;
            cin = '{word: 16'h8420 | 16'(k), is_tx: k[0], chan_a: !k[0]};
            pd = 1'h1;
            tick(1);
            pd = 1'h0;
            stx = 1'h1;
            tick(1);
            stx = 1'h0;
            tick(25);
            chk("chan", 16'(chan), 16'(!k[0]));
            chk("cmd_status", cstat, 16'h8420 | 16'(k));
            chk("err_set", 16'(merr), 16'h1);
            tick(10);
            chk("strobe", 16'(cstb), 16'h1);
            chk("transmit_ind", 16'(xmt), 16'(k[0]));
            chk("rcv", 16'(receive_ind), 16'(!k[0]));
            chk("timer_rel", 16'(tmr_n), 16'h1);
            tick(4);
            chk("strobe_hold", 16'(cstb), 16'h1);
            tick(1);
            chk("strobe_end", 16'(cstb), 16'h0);
            tick(4);
            chk("err_clr", 16'(merr), 16'h0);
        end
        for (int i = 0; i < 2; i++) begin
            a0 = i[0];
            rd_n = 1'h0;
            tick(3);
            chk("data_oe", 16'(doe), 16'h1);
            chk("data_out", dout, i ? 16'h8421 : sysr);
            rd_n = 1'h1;
            tick(3);
            chk("data_rel", 16'(doe), 16'h0);
        end
        stx = 1'h1;
        tick(1);
        stx = 1'h0;
        tick(5);
        chk("timer_on", 16'(tmr_n), 16'h0);
        chk("permit_early", 16'(permit), 16'h0);
        tick(9);
        chk("permit", 16'(permit), 16'h1);
        tick(TCYC);
        chk("timer_end", 16'(tmr_n), 16'h1);
        end_of_test();
    end
endmodule
